//--- rtl/seq_pkg.sv
// Shared constants for the programmable Mealy sequencer.
package seq_pkg;
  localparam int NUM_TERMS = 64;
  localparam int NUM_INPUTS = 16;
  localparam int NUM_STATE = 8;
  localparam int NUM_OUT = 8;
  localparam int HALF = 4;
  // Literal columns per term: inputs, state feedback, two complement signals.
  localparam int NUM_LITS = NUM_INPUTS + NUM_STATE + 2;
  // Index of the logic input shared with the second clock pin.
  localparam int SHARED_PIN_IDX = 5;
  // Literal codes.
  localparam logic [1:0] LIT_DONT_CARE = 2'h0;
  localparam logic [1:0] LIT_TRUE = 2'h1;
  localparam logic [1:0] LIT_COMP = 2'h2;
  localparam logic [1:0] LIT_NEVER = 2'h3;
  // Power-up value of every register bit.
  localparam logic [7:0] POWER_UP_VALUE = 8'hff;
  // Diagnostic mode select.
  typedef enum {DIAG_NONE, DIAG_VIEW_STATE, DIAG_LOAD_STATE, DIAG_LOAD_OUT} diag_mode_t;
endpackage

//--- rtl/jk_bank.sv
// A bank of J-K register bits with diagnostic load and clocked init.
`timescale 1ns/1ns
module jk_bank
  import seq_pkg::*;
#(
  parameter int WIDTH = 4
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic update_en,
  input wire logic init_active,
  input wire logic [WIDTH-1:0] init_value,
  input wire logic load_en,
  input wire logic hold_en,
  input wire logic [WIDTH-1:0] load_value,
  input wire logic [WIDTH-1:0] j_in,
  input wire logic [WIDTH-1:0] k_in,
  output logic [WIDTH-1:0] q
);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      q <= WIDTH'(POWER_UP_VALUE);
    end
    else if (init_active)
    begin
      q <= init_value;
    end
    else if (update_en)
    begin
      if (load_en)
      begin
        q <= load_value;
      end
      else if (!hold_en)
      begin
        for (int i = 0; i < WIDTH; i++)
        begin
          unique case ({j_in[i], k_in[i]})
            2'b00: q[i] <= q[i];
            2'b01: q[i] <= 1'b0;
            2'b10: q[i] <= 1'b1;
            2'b11: q[i] <= ~q[i];
          endcase
        end
      end
    end
  end

endmodule

//--- rtl/mealy_sequencer.sv
// Field-programmable registered Mealy sequencer with J-K state and output registers.
// Functional notes
// - 64 terms over 16 inputs and state
// - Each literal true, complemented or ignored
// - Two complement signals feed the terms
// - Complement signal low when any linked term
// - Any term sums into any J or K
// - Eight state and eight output J-K bits
// - Primary clock updates all, or low half
// - Fourth pin is input or second clock
// - Init forces programmed preset or reset pattern
// - Init overrides clock, registers hold init values
// - Restart after first full pulse after fall
// - Power-up presets every register bit to one
// - Shared pin may be active-low output enable
// - Outputs show output register when enabled
// - State-view mode shows state on outputs
// - State-load mode loads pins into state
// - Output-load mode loads pins into outputs
// - Drivers off during register-load modes
// - Diagnostic pins otherwise act as logic inputs
`timescale 1ns/1ns
module mealy_sequencer
  import seq_pkg::*;
#(
  parameter int TERMS = NUM_TERMS
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic primary_clock,
  input wire logic secondary_clock_or_input,
  input wire logic [NUM_INPUTS-1:0] logic_inputs,
  input wire logic state_view_diag_input,
  input wire logic state_load_diag_input,
  input wire logic output_load_diag_input,
  input wire logic init_or_oe_pin,
  input wire logic cfg_init_not_oe,
  input wire logic cfg_split_clock,
  input wire logic [NUM_STATE-1:0] cfg_state_init,
  input wire logic [NUM_OUT-1:0] cfg_out_init,
  input wire logic [TERMS-1:0][NUM_LITS-1:0][1:0] cfg_and_array,
  input wire logic [TERMS-1:0] cfg_comp_a_link,
  input wire logic [TERMS-1:0] cfg_comp_b_link,
  input wire logic [NUM_STATE-1:0][TERMS-1:0] cfg_state_j,
  input wire logic [NUM_STATE-1:0][TERMS-1:0] cfg_state_k,
  input wire logic [NUM_OUT-1:0][TERMS-1:0] cfg_out_j,
  input wire logic [NUM_OUT-1:0][TERMS-1:0] cfg_out_k,
  input wire logic [NUM_OUT-1:0] output_pins_in,
  output logic [NUM_OUT-1:0] output_pins_out,
  output logic [NUM_OUT-1:0] output_pins_oe_n,
  output logic [NUM_STATE-1:0] state_bits,
  output logic [NUM_OUT-1:0] output_register_bits
);

  // One literal of a product term; a never code disables the term.
  function automatic logic lit_ok(input logic [1:0] code, input logic v);
    unique case (code)
      LIT_DONT_CARE: lit_ok = 1'b1;
      LIT_TRUE: lit_ok = v;
      LIT_COMP: lit_ok = ~v;
      LIT_NEVER: lit_ok = 1'b0;
    endcase
  endfunction

  // OR of the terms selected by a mask.
  function automatic logic or_sel(input logic [TERMS-1:0] terms, input logic [TERMS-1:0] sel);
    or_sel = |(terms & sel);
  endfunction

  logic prim_d_reg;
  logic sec_d_reg;
  logic prim_armed_reg;
  logic sec_armed_reg;
  logic prim_rise;
  logic sec_rise;
  logic prim_fall;
  logic sec_fall;
  logic init_active;
  logic oe_active_n;
  diag_mode_t diag_mode;
  logic [NUM_INPUTS-1:0] eff_inputs;
  logic [TERMS-1:0] base_terms;
  logic [TERMS-1:0] terms;
  logic comp_a;
  logic comp_b;
  logic [NUM_STATE-1:0] st_j;
  logic [NUM_STATE-1:0] st_k;
  logic [NUM_OUT-1:0] out_j;
  logic [NUM_OUT-1:0] out_k;
  logic lo_update;
  logic hi_update;
  logic [NUM_STATE-1:0] state_q;
  logic [NUM_OUT-1:0] out_q;
  logic [NUM_OUT-1:0] pins_next;
  logic [NUM_OUT-1:0] oe_n_next;
  logic view_mode;
  logic load_state_mode;
  logic load_out_mode;
  logic pins_released;

  // Clock pins are sampled; edges become one-cycle enables.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prim_d_reg <= 1'b0;
      sec_d_reg <= 1'b0;
    end
    else
    begin
      prim_d_reg <= primary_clock;
      sec_d_reg <= secondary_clock_or_input;
    end
  end

  assign prim_rise = primary_clock & ~prim_d_reg;
  assign prim_fall = ~primary_clock & prim_d_reg;
  assign sec_rise = secondary_clock_or_input & ~sec_d_reg;
  assign sec_fall = ~secondary_clock_or_input & sec_d_reg;

  assign init_active = cfg_init_not_oe & init_or_oe_pin;
  assign oe_active_n = cfg_init_not_oe ? 1'b0 : init_or_oe_pin;

  // After init, a rising edge counts only once a falling edge was seen, so a
  // clock already high at release cannot produce a partial first pulse.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prim_armed_reg <= 1'b1;
      sec_armed_reg <= 1'b1;
    end
    else if (init_active)
    begin
      prim_armed_reg <= 1'b0;
      sec_armed_reg <= 1'b0;
    end
    else
    begin
      if (prim_fall)
      begin
        prim_armed_reg <= 1'b1;
      end
      if (sec_fall)
      begin
        sec_armed_reg <= 1'b1;
      end
    end
  end

  // High-voltage diagnostic levels arrive as separate qualifier inputs.
  always_comb
  begin
    if (state_view_diag_input)
    begin
      diag_mode = DIAG_VIEW_STATE;
    end
    else if (state_load_diag_input)
    begin
      diag_mode = DIAG_LOAD_STATE;
    end
    else if (output_load_diag_input)
    begin
      diag_mode = DIAG_LOAD_OUT;
    end
    else
    begin
      diag_mode = DIAG_NONE;
    end
  end

  // Both load modes hand the pins to the board, so our drivers must let go.
  assign view_mode = diag_mode == DIAG_VIEW_STATE;
  assign load_state_mode = diag_mode == DIAG_LOAD_STATE;
  assign load_out_mode = diag_mode == DIAG_LOAD_OUT;
  assign pins_released = load_state_mode | load_out_mode;

  // Logic inputs stay logic inputs at normal levels; the shared pin feeds the
  // array directly without split clock; with split clock it reads as 0, so its literals must be don't care.
  always_comb
  begin
    eff_inputs = logic_inputs;
    eff_inputs[SHARED_PIN_IDX] = cfg_split_clock ? 1'b0 : secondary_clock_or_input;
  end

  // Complement signals break the term loop by using only the input and state
  // literals of the linked terms, leaving out their complement literals.
  always_comb
  begin
    for (int t = 0; t < TERMS; t++)
    begin
      base_terms[t] = 1'b1;
      for (int i = 0; i < NUM_INPUTS; i++)
      begin
        base_terms[t] = base_terms[t] & lit_ok(cfg_and_array[t][i], eff_inputs[i]);
      end
      for (int s = 0; s < NUM_STATE; s++)
      begin
        base_terms[t] = base_terms[t]
          & lit_ok(cfg_and_array[t][NUM_INPUTS+s], state_q[s]);
      end
    end
  end

  assign comp_a = ~or_sel(base_terms, cfg_comp_a_link);
  assign comp_b = ~or_sel(base_terms, cfg_comp_b_link);

  always_comb
  begin
    for (int t = 0; t < TERMS; t++)
    begin
      terms[t] = base_terms[t]
        & lit_ok(cfg_and_array[t][NUM_LITS-2], comp_a)
        & lit_ok(cfg_and_array[t][NUM_LITS-1], comp_b);
    end
  end

  always_comb
  begin
    for (int b = 0; b < NUM_STATE; b++)
    begin
      st_j[b] = or_sel(terms, cfg_state_j[b]);
      st_k[b] = or_sel(terms, cfg_state_k[b]);
    end
    for (int b = 0; b < NUM_OUT; b++)
    begin
      out_j[b] = or_sel(terms, cfg_out_j[b]);
      out_k[b] = or_sel(terms, cfg_out_k[b]);
    end
  end

  // Without split clock the upper half simply follows the primary enable.
  assign lo_update = prim_rise & prim_armed_reg;
  assign hi_update = cfg_split_clock ? (sec_rise & sec_armed_reg) : lo_update;

  // Each half has its own enable, so split-clock mode keeps the two machines apart.
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : half_gen
      localparam int LO = g * HALF;
      jk_bank #(.WIDTH(HALF)) state_bank (
        .clk(clk),
        .reset_n(reset_n),
        .update_en(g == 0 ? lo_update : hi_update),
        .init_active(init_active),
        .init_value(cfg_state_init[LO +: HALF]),
        .load_en(load_state_mode),
        .hold_en(load_out_mode),
        .load_value(output_pins_in[LO +: HALF]),
        .j_in(st_j[LO +: HALF]),
        .k_in(st_k[LO +: HALF]),
        .q(state_q[LO +: HALF])
      );
      jk_bank #(.WIDTH(HALF)) out_bank (
        .clk(clk),
        .reset_n(reset_n),
        .update_en(g == 0 ? lo_update : hi_update),
        .init_active(init_active),
        .init_value(cfg_out_init[LO +: HALF]),
        .load_en(load_out_mode),
        .hold_en(load_state_mode | view_mode),
        .load_value(output_pins_in[LO +: HALF]),
        .j_in(out_j[LO +: HALF]),
        .k_in(out_k[LO +: HALF]),
        .q(out_q[LO +: HALF])
      );
    end
  endgenerate

  // Pin values are registered, so they lag the registers by one cycle.
  always_comb
  begin
    pins_next = view_mode ? state_q : out_q;
    oe_n_next = {NUM_OUT{oe_active_n}};
    if (pins_released)
    begin
      oe_n_next = {NUM_OUT{1'b1}};
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      output_pins_out <= POWER_UP_VALUE;
      output_pins_oe_n <= {NUM_OUT{1'b1}};
      state_bits <= POWER_UP_VALUE;
      output_register_bits <= POWER_UP_VALUE;
    end
    else
    begin
      output_pins_out <= pins_next;
      output_pins_oe_n <= oe_n_next;
      state_bits <= state_q;
      output_register_bits <= out_q;
    end
  end

endmodule

//--- tb/mealy_sequencer_properties.sv
// Port-level property checker for the programmable sequencer.
`timescale 1ns/1ns
module mealy_sequencer_properties
  import seq_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic primary_clock,
  input wire logic secondary_clock_or_input,
  input wire logic state_view_diag_input,
  input wire logic state_load_diag_input,
  input wire logic output_load_diag_input,
  input wire logic init_or_oe_pin,
  input wire logic cfg_init_not_oe,
  input wire logic [NUM_STATE-1:0] cfg_state_init,
  input wire logic [NUM_OUT-1:0] output_pins_out,
  input wire logic [NUM_OUT-1:0] output_pins_oe_n,
  input wire logic [NUM_STATE-1:0] state_bits,
  input wire logic [NUM_OUT-1:0] output_register_bits
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // Outputs lag the registers by one edge, so most antecedents span three samples.
  wire ini = cfg_init_not_oe && init_or_oe_pin;
  wire off = !cfg_init_not_oe && init_or_oe_pin;
  wire vw = state_view_diag_input;
  wire sl = !vw && state_load_diag_input;
  wire ol = !vw && !state_load_diag_input && output_load_diag_input;
  AST_POWER_UP: assert property ($rose(reset_n) |-> state_bits == POWER_UP_VALUE ##1
    (state_bits == POWER_UP_VALUE && output_register_bits == POWER_UP_VALUE))
    else $error("power-up value wrong");
  AST_INIT: assert property (ini [*3] |-> state_bits == cfg_state_init)
    else $error("init pattern wrong");
  AST_VIEW: assert property (vw [*3] |-> output_pins_out == state_bits)
    else $error("state view wrong");
  AST_OE_OFF: assert property (off [*3] |-> output_pins_oe_n == 8'hff)
    else $error("drivers not off");
  AST_LOAD_OFF: assert property ((sl || ol) [*3] |-> output_pins_oe_n == 8'hff)
    else $error("drivers on in load mode");
  AST_SHOW: assert property ((!ini && !off && !vw && !sl && !ol) [*3] |->
    output_pins_oe_n == 8'h00 && output_pins_out == output_register_bits)
    else $error("pins not showing outputs");
  AST_STATE_LOAD: assert property (sl [*3] |-> $stable(output_register_bits))
    else $error("output register moved");
  AST_OUT_LOAD: assert property (ol [*3] |-> $stable(state_bits))
    else $error("state register moved");
  AST_NO_EDGE: assert property ((!primary_clock && !secondary_clock_or_input && !ini) [*4] |->
    $stable(state_bits))
    else $error("state moved without clock");
  cover property (ini ##1 !ini);
  cover property (vw [*3]);
  cover property (ol && $rose(primary_clock));
endmodule
bind mealy_sequencer mealy_sequencer_properties mealy_sequencer_properties_i (
  .clk(clk),
  .reset_n(reset_n),
  .primary_clock(primary_clock),
  .secondary_clock_or_input(secondary_clock_or_input),
  .state_view_diag_input(state_view_diag_input),
  .state_load_diag_input(state_load_diag_input),
  .output_load_diag_input(output_load_diag_input),
  .init_or_oe_pin(init_or_oe_pin),
  .cfg_init_not_oe(cfg_init_not_oe),
  .cfg_state_init(cfg_state_init),
  .output_pins_out(output_pins_out),
  .output_pins_oe_n(output_pins_oe_n),
  .state_bits(state_bits),
  .output_register_bits(output_register_bits)
);

//--- tb/board_partner.sv
// Board-side model that drives the shared output pins.
`timescale 1ns/1ns
module board_partner
(
  input wire logic [7:0] output_pins_oe_n,
  input wire logic [7:0] output_pins_out,
  input wire logic [7:0] drive_value,
  output logic [7:0] output_pins_in
);
  // The board only drives a pin once the device has let go of it.
  assign output_pins_in = (output_pins_out & ~output_pins_oe_n) | (drive_value & output_pins_oe_n);
endmodule

//--- tb/tb_mealy_sequencer.sv
// Self-checking bench for the programmable sequencer.
`timescale 1ns/1ns
module tb_mealy_sequencer
  import seq_pkg::*;
;
  logic clk = 0, reset_n = 0, primary_clock = 0, secondary_clock_or_input = 0;
  logic state_view_diag_input = 0, state_load_diag_input = 0, output_load_diag_input = 0;
  logic init_or_oe_pin = 0, cfg_init_not_oe = 1, cfg_split_clock = 0;
  logic [15:0] logic_inputs = 16'h0000;
  logic [7:0] cfg_state_init = 8'h5a, cfg_out_init = 8'ha5, drive_value = 8'h00;
  logic [NUM_TERMS-1:0][NUM_LITS-1:0][1:0] cfg_and_array;
  logic [NUM_TERMS-1:0] cfg_comp_a_link, cfg_comp_b_link;
  logic [NUM_STATE-1:0][NUM_TERMS-1:0] cfg_state_j, cfg_state_k;
  logic [NUM_OUT-1:0][NUM_TERMS-1:0] cfg_out_j, cfg_out_k;
  logic [7:0] output_pins_in, output_pins_out, output_pins_oe_n, state_bits, output_register_bits;
  int failures = 0, n_checks = 0, cycles = 0;
  mealy_sequencer mealy_sequencer_i (
    .clk(clk),
    .reset_n(reset_n),
    .primary_clock(primary_clock),
    .secondary_clock_or_input(secondary_clock_or_input),
    .logic_inputs(logic_inputs),
    .state_view_diag_input(state_view_diag_input),
    .state_load_diag_input(state_load_diag_input),
    .output_load_diag_input(output_load_diag_input),
    .init_or_oe_pin(init_or_oe_pin),
    .cfg_init_not_oe(cfg_init_not_oe),
    .cfg_split_clock(cfg_split_clock),
    .cfg_state_init(cfg_state_init),
    .cfg_out_init(cfg_out_init),
    .cfg_and_array(cfg_and_array),
    .cfg_comp_a_link(cfg_comp_a_link),
    .cfg_comp_b_link(cfg_comp_b_link),
    .cfg_state_j(cfg_state_j),
    .cfg_state_k(cfg_state_k),
    .cfg_out_j(cfg_out_j),
    .cfg_out_k(cfg_out_k),
    .output_pins_in(output_pins_in),
    .output_pins_out(output_pins_out),
    .output_pins_oe_n(output_pins_oe_n),
    .state_bits(state_bits),
    .output_register_bits(output_register_bits)
  );
  board_partner board_partner_i (
    .output_pins_oe_n(output_pins_oe_n),
    .output_pins_out(output_pins_out),
    .drive_value(drive_value),
    .output_pins_in(output_pins_in)
  );
  initial
  begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      failures++;
      complete_run;
    end
  end
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task regs(input logic [7:0] s, input logic [7:0] o);
    chk("state", state_bits, s);
    chk("outreg", output_register_bits, o);
  endtask
  // Pulses are kept two cycles high and four low, longer than the one cycle of each level the sampler needs.
  task pulse(input bit sec);
    if (sec)
      secondary_clock_or_input <= 1'h1;
    else
      primary_clock <= 1'h1;
    repeat (2) @(posedge clk);
    primary_clock <= 1'h0;
    secondary_clock_or_input <= 1'h0;
    repeat (4) @(posedge clk);
  endtask
  task t_split;
    cfg_split_clock <= 1'h1;
    logic_inputs <= 16'h0003;
    pulse(0);
    regs(8'hfc, 8'hfe);
    pulse(1);
    regs(8'hec, 8'hfe);
    cfg_split_clock <= 1'h0;
  endtask
  task t_init;
    init_or_oe_pin <= 1'h1;
    pulse(0);
    regs(8'h5a, 8'ha5);
    init_or_oe_pin <= 1'h0;
    repeat (2) @(posedge clk);
    pulse(0);
    regs(8'h5a, 8'ha5);
    pulse(0);
    regs(8'h49, 8'ha6);
    logic_inputs <= 16'h0001;
    pulse(0);
    regs(8'h5c, 8'ha7);
  endtask
  task t_diag;
    state_view_diag_input <= 1'h1;
    repeat (3) @(posedge clk);
    chk("view", output_pins_out, 8'h5c);
    state_view_diag_input <= 1'h0;
    state_load_diag_input <= 1'h1;
    drive_value <= 8'h3c;
    repeat (3) @(posedge clk);
    chk("oe", output_pins_oe_n, 8'hff);
    pulse(0);
    regs(8'h3c, 8'ha7);
    state_load_diag_input <= 1'h0;
    output_load_diag_input <= 1'h1;
    drive_value <= 8'hc3;
    pulse(0);
    regs(8'h3c, 8'hc3);
    output_load_diag_input <= 1'h0;
  endtask
  task t_oe;
    cfg_init_not_oe <= 1'h0;
    init_or_oe_pin <= 1'h1;
    repeat (3) @(posedge clk);
    chk("oe", output_pins_oe_n, 8'hff);
    init_or_oe_pin <= 1'h0;
    repeat (3) @(posedge clk);
    chk("oe", output_pins_oe_n, 8'h00);
    chk("pins", output_pins_out, 8'hc3);
  endtask
  task complete_run;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    for (int t = 0; t < NUM_TERMS; t++)
      for (int c = 0; c < NUM_LITS; c++)
        cfg_and_array[t][c] = (c == SHARED_PIN_IDX || t < 5) ? LIT_DONT_CARE : LIT_NEVER;
    cfg_and_array[1][0] = LIT_TRUE;
    cfg_and_array[2][1] = LIT_TRUE;
    cfg_and_array[3][NUM_INPUTS+NUM_STATE] = LIT_TRUE;
    cfg_and_array[4][2] = LIT_COMP;
    cfg_comp_a_link = 64'h4;
    cfg_comp_b_link = 64'h0;
    {cfg_state_j, cfg_state_k, cfg_out_j, cfg_out_k} = '0;
    cfg_state_j[0] = 64'h1;
    cfg_state_k[0] = 64'h1;
    cfg_state_k[1] = 64'h2;
    cfg_state_j[2] = 64'h8;
    cfg_state_j[4] = 64'h10;
    cfg_state_k[4] = 64'h10;
    cfg_out_j[0] = 64'h1;
    cfg_out_k[0] = 64'h1;
    cfg_out_j[1] = 64'h2;
    repeat (10) @(posedge clk);
    reset_n <= 1'h1;
    repeat (2) @(posedge clk);
    regs(8'hff, 8'hff);
    t_split;
    t_init;
    t_diag;
    t_oe;
    complete_run;
  end
endmodule
